// [sar_adc_conversion_handshake_test.sv]
`timescale 1ns/1ns
module sar_adc_conversion_handshake_test;
  import sar_pkg::*;
  typedef struct {
    logic [DATA_W-1:0] level;
    logic              bip;
    logic [RES_W-1:0]  res;
    logic              fast;
  } row_t;

  logic              clk_sys       = 1'b0;
  logic              reset         = 1'b1;
  logic              start         = 1'b0;
  logic              bipolar_range = 1'b0;
  logic              fast_variant  = 1'b1;
  logic [RES_W-1:0]  res_bits      = RES_MAX;
  logic [DATA_W-1:0] analog_level  = 16'h0000;
  logic              ready;
  logic              sha_hold;
  logic              result_valid;
  logic [DATA_W-1:0] result_code;
  logic [DATA_W-1:0] result_twos;
  code_kind_t        result_kind;
  code_kind_t        code_kind;
  logic [RES_W-1:0]  res_used;
  logic [DATA_W-1:0] exp_code;
  int                bad_count       = 0;
  int                samples_checked = 0;
  int                busy_cyc;
  row_t rows [6] = '{'{16'hFFFF, 1'b0, RES_MAX, 1'b1}, '{16'h8000, 1'b1, RES_MAX, 1'b1},
                     '{16'h0001, 1'b1, RES_MAX, 1'b1}, '{16'hABCD, 1'b0, RES_SHORT, 1'b0},
                     '{16'h5A5A, 1'b1, RES_SHORT, 1'b1}, '{16'h00FF, 1'b0, RES_MIN, 1'b1}};

  always #2 clk_sys = ~clk_sys;

  sar_link_if link ();
  sar_adc_device u_sar_adc_device (.clk_sys, .reset, .link, .analog_level, .bipolar_range,
                                   .fast_variant, .res_bits, .code_kind, .res_used);
  sar_adc_host u_sar_adc_host (.clk_sys, .reset, .link, .start, .bipolar_range, .ready, .sha_hold,
                               .result_valid, .result_code, .result_twos, .result_kind);
  sar_link_asserts u_sar_link_asserts (.clk_sys, .reset, .conv_start(link.conv_start),
                                       .busy(link.busy), .gated_clk(link.gated_clk),
                                       .data_n(link.data_n));

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic convert(input row_t r);
    int n;
    int d;
    code_kind_t k;
    analog_level = r.level;
    bipolar_range = r.bip;
    res_bits = r.res;
    fast_variant = r.fast;
    exp_code = ~(r.level & (16'hFFFF << (DATA_W - int'(r.res))));
    k = r.bip ? inverted_offset_code : inverted_plain_code;
    while (ready !== 1'b1) @(posedge clk_sys) #1;
    start = 1'b1;
    @(posedge clk_sys) #1 start = 1'b0;
    busy_cyc = 0;
    n = 0;
    while (result_valid !== 1'b1 && n < 6000) begin
      @(posedge clk_sys) #1 n++;
      if (link.busy === 1'b1) busy_cyc++;
      start = (n == 100);
      if (n == 100) check(16'(sha_hold), 16'h0001);
      if (n == 100) check(16'(ready), 16'h0000);
    end
    if (n >= 6000) check(16'h0000, 16'h0001);
    check(result_code, exp_code);
    check(link.data_n, ~exp_code);
    check(result_twos, r.bip ? exp_code ^ MSB_MASK : exp_code);
    check(16'(result_kind), 16'(k));
    check(16'(code_kind), 16'(k));
    check(16'(sha_hold), 16'h0000);
    check(16'(res_used), 16'(r.res));
    d = busy_cyc * 1000 / CLK_MHZ - (r.fast ? CONV14_FAST_NS : CONV14_SLOW_NS);
    if (r.res == RES_SHORT) check(16'(d < 500 && d > -500), 16'h0001);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #1 reset = 1'b0;
    check(16'({link.busy, link.gated_clk, link.conv_start, sha_hold, result_valid}), 16'h0000);
    check(link.data_n, ZERO_WORD);
    foreach (rows[i]) convert(rows[i]);
    repeat (50) @(posedge clk_sys);
    #1 check(result_code, exp_code);
    start = 1'b1;
    @(posedge clk_sys) #1 start = 1'b0;
    repeat (500) @(posedge clk_sys);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check(16'({link.busy, link.gated_clk, sha_hold}), 16'h0000);
    reset = 1'b0;
    convert(rows[1]);
    summarize();
  end

  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule

// [sar_adc_device.sv]
`timescale 1ns/1ns
module sar_adc_device (
  // System
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // Link to host
  sar_link_if.dev                          link,
  // Analog side, input position in range
  input  wire logic [sar_pkg::DATA_W-1:0]  analog_level,
  input  wire logic                        bipolar_range,
  // Straps
  input  wire logic                        fast_variant,
  input  wire logic [sar_pkg::RES_W-1:0]   res_bits,
  // Status
  output sar_pkg::code_kind_t              code_kind,
  output logic [sar_pkg::RES_W-1:0]        res_used
);
  import sar_pkg::*;

  // Clamp short-cycle resolution
  function automatic logic [RES_W-1:0] clamp_res(input logic [RES_W-1:0] r);
    logic [RES_W-1:0] v;
    v = r;
    if (r < RES_MIN) begin
      v = RES_MIN;
    end else if (r > RES_MAX) begin
      v = RES_MAX;
    end
    return v;
  endfunction

  // True binary to inverted output code
  function automatic logic [DATA_W-1:0] to_code(input logic [DATA_W-1:0] t);
    return ~t; // R4 R5
  endfunction

  // Output code to negative-true pin levels
  function automatic logic [DATA_W-1:0] to_pins(input logic [DATA_W-1:0] c);
    return ~c; // R13
  endfunction

  dev_state_t       state_r;
  logic             req_prev_r;
  logic             req_fall;
  logic             busy_r;
  logic [RES_W-1:0] res_r;
  logic [RES_W-1:0] tick_idx_r;
  logic [DATA_W-1:0] trial_r;
  logic [DATA_W-1:0] sar_r;
  logic [DATA_W-1:0] sar_dec;
  logic             keep_bit;
  logic [DATA_W-1:0] pins_r;
  logic [CNT_W-1:0] lead_cnt_r;
  code_kind_t       kind_r;
  logic             clk_run;
  logic             gtick;
  logic             gclk;
  logic             start_ok;
  logic             last_tick;

  assign link.busy      = busy_r;
  assign link.data_n    = pins_r;
  assign link.gated_clk = gclk;
  assign code_kind      = kind_r;
  assign res_used       = res_r;

  // Falling edge of the request starts a conversion
  assign req_fall = req_prev_r && !link.conv_start; // R1
  assign start_ok = req_fall && (state_r == DEV_IDLE); // R14

  // Clock runs from start, forced low on the edge that drops busy
  assign clk_run = (state_r == DEV_CONV) || (state_r == DEV_LEAD && lead_cnt_r != '0); // R11

  // Bit decision against the analog level
  assign keep_bit  = ((sar_r | trial_r) <= analog_level);
  assign sar_dec   = keep_bit ? (sar_r | trial_r) : sar_r;
  assign last_tick = gtick && (tick_idx_r == res_r);

  sar_gated_clock u_gclk (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .run          (clk_run),
    .fast_variant (fast_variant),
    .gclk         (gclk),
    .tick         (gtick)
  );

  // Request edge detect
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      req_prev_r <= 1'b0;
    end else begin
      req_prev_r <= link.conv_start;
    end
  end

  // Conversion sequencing
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= DEV_IDLE;
    end else begin
      case (state_r)
        DEV_IDLE: begin
          if (start_ok) begin
            state_r <= DEV_CONV; // R1
          end
        end
        DEV_CONV: begin
          if (last_tick) begin
            state_r <= DEV_LEAD;
          end
        end
        DEV_LEAD: begin
          if (lead_cnt_r == '0) begin
            state_r <= DEV_IDLE;
          end
        end
        default: begin
          state_r <= DEV_IDLE;
        end
      endcase
    end
  end

  // Busy flag high through the whole conversion
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else if (start_ok) begin
      busy_r <= 1'b1; // R1
    end else if (state_r == DEV_LEAD && lead_cnt_r == '0) begin
      busy_r <= 1'b0; // R2
    end
  end

  // Resolution and code kind caught at start
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      res_r  <= RES_MAX;
      kind_r <= inverted_plain_code;
    end else if (start_ok) begin
      res_r  <= clamp_res(res_bits);
      kind_r <= bipolar_range ? inverted_offset_code : inverted_plain_code; // R5
    end
  end

  // Gated clock edge counter
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_idx_r <= '0;
    end else if (start_ok) begin
      tick_idx_r <= '0;
    end else if (gtick && state_r == DEV_CONV) begin
      tick_idx_r <= tick_idx_r + 1'b1; // R11
    end
  end

  // Trial bit walks from MSB down
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trial_r <= ZERO_WORD;
    end else if (start_ok) begin
      trial_r <= ZERO_WORD; // R3
    end else if (gtick && state_r == DEV_CONV) begin
      if (tick_idx_r == '0) begin
        trial_r <= MSB_MASK;
      end else begin
        trial_r <= trial_r >> 1;
      end
    end
  end

  // Approximation register keeps accepted bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sar_r <= ZERO_WORD;
    end else if (start_ok) begin
      sar_r <= ZERO_WORD; // R3
    end else if (gtick && state_r == DEV_CONV && tick_idx_r != '0) begin
      sar_r <= sar_dec;
    end
  end

  // Result pins updated only at the last decision
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pins_r <= to_pins(to_code(ZERO_WORD));
    end else if (last_tick && state_r == DEV_CONV) begin
      pins_r <= to_pins(to_code(sar_dec)); // R4 R13 R14
    end
  end

  // Data stands before busy falls
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lead_cnt_r <= '0;
    end else if (last_tick && state_r == DEV_CONV) begin
      lead_cnt_r <= DATA_LEAD_CYC - 1'b1; // R12
    end else if (state_r == DEV_LEAD && lead_cnt_r != '0) begin
      lead_cnt_r <= lead_cnt_r - 1'b1;
    end
  end
endmodule

// [sar_adc_host.sv]
`timescale 1ns/1ns
module sar_adc_host (
  // System
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // Link to converter
  sar_link_if.host                         link,
  // User request
  input  wire logic                        start,
  input  wire logic                        bipolar_range,
  output logic                             ready,
  // Sample-and-hold control
  output logic                             sha_hold,
  // Result
  output logic                             result_valid,
  output logic [sar_pkg::DATA_W-1:0]       result_code,
  output logic [sar_pkg::DATA_W-1:0]       result_twos,
  output sar_pkg::code_kind_t              result_kind
);
  import sar_pkg::*;

  host_state_t      state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             req_r;
  logic             hold_r;
  logic             busy_prev_r;
  logic             busy_fall;
  logic             valid_r;
  logic [DATA_W-1:0] code_r;
  logic [DATA_W-1:0] twos_r;
  code_kind_t       kind_r;
  logic [DATA_W-1:0] code_in;

  assign link.conv_start = req_r;
  assign sha_hold        = hold_r;
  assign result_valid    = valid_r;
  assign result_code     = code_r;
  assign result_twos     = twos_r;
  assign result_kind     = kind_r;
  assign ready           = (state_r == HOST_IDLE) && !link.busy;
  assign busy_fall       = busy_prev_r && !link.busy;
  assign code_in         = ~link.data_n;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy_prev_r <= 1'b0;
    end else begin
      busy_prev_r <= link.busy;
    end
  end

  // Request pulse sequencing
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= HOST_IDLE;
      cnt_r   <= '0;
      req_r   <= 1'b0;
    end else begin
      case (state_r)
        HOST_IDLE: begin
          if (start && ready) begin
            state_r <= HOST_PULSE;
            req_r   <= 1'b1;
            cnt_r   <= REQ_PULSE_CYC - 1'b1;
          end
        end
        HOST_PULSE: begin
          if (cnt_r == '0) begin
            req_r   <= 1'b0; // R9
            state_r <= HOST_WAIT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        HOST_WAIT: begin
          if (busy_fall) begin
            state_r <= HOST_IDLE;
          end
        end
        default: begin
          state_r <= HOST_IDLE;
        end
      endcase
    end
  end

  // Hold on request rise, track on busy fall
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_r <= 1'b0;
    end else if (state_r == HOST_IDLE && start && ready) begin
      hold_r <= 1'b1; // R7
    end else if (state_r == HOST_WAIT && busy_fall) begin
      hold_r <= 1'b0; // R8
    end
  end

  // Result capture on busy fall
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      valid_r <= 1'b0;
      code_r  <= ZERO_WORD;
      twos_r  <= ZERO_WORD;
      kind_r  <= inverted_plain_code;
    end else begin
      valid_r <= (state_r == HOST_WAIT) && busy_fall;
      if (state_r == HOST_WAIT && busy_fall) begin
        code_r <= code_in;
        kind_r <= bipolar_range ? inverted_offset_code : inverted_plain_code;
        twos_r <= bipolar_range ? (code_in ^ MSB_MASK) : code_in; // R6
      end
    end
  end
endmodule

// [sar_gated_clock.sv]
`timescale 1ns/1ns
module sar_gated_clock (
  // System
  input  wire logic clk_sys,
  input  wire logic reset,
  // Control
  input  wire logic run,
  input  wire logic fast_variant,
  // Clock out
  output logic      gclk,
  output logic      tick
);
  import sar_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic             gclk_r;
  logic             tick_r;
  logic [CNT_W-1:0] half;

  assign half = fast_variant ? HALF_FAST : HALF_SLOW; // R10
  assign gclk = gclk_r;
  assign tick = tick_r;

  // Divider, forced low while inhibited
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      cnt_r  <= '0;
      gclk_r <= 1'b0; // R11
    end else if (cnt_r == half - 1'b1) begin
      cnt_r  <= '0;
      gclk_r <= ~gclk_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // One-cycle pulse with each rising edge
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cnt_r == half - 1'b1) && !gclk_r;
    end
  end
endmodule

// [sar_link_asserts.sv]
`timescale 1ns/1ns
module sar_link_asserts (
  // System
  input wire logic                       clk_sys,
  input wire logic                       reset,
  // Link
  input wire logic                       conv_start,
  input wire logic                       busy,
  input wire logic                       gated_clk,
  input wire logic [sar_pkg::DATA_W-1:0] data_n
);
  import sar_pkg::*;
  logic [12:0] busy_cyc_r;
  logic [4:0]  rise_cnt_r;
  logic        gclk_d_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Busy length counter
  always_ff @(posedge clk_sys) begin
    if (reset || !busy) busy_cyc_r <= '0;
    else busy_cyc_r <= busy_cyc_r + 1'b1;
  end

  // Gated clock rises per conversion
  always_ff @(posedge clk_sys) begin
    gclk_d_r <= gated_clk;
    if (reset || !busy) rise_cnt_r <= '0;
    else if (gated_clk && !gclk_d_r) rise_cnt_r <= rise_cnt_r + 1'b1;
  end

  AST_BUSY_RISE: assert property ($fell(conv_start) && !busy |-> ##[1:2] busy)
    else $error("busy did not follow request fall");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> !$past(conv_start))
    else $error("busy rose without request fall");
  AST_START_LOW: assert property ($rose(busy) |-> !gated_clk)
    else $error("gated clock not low at conversion start");
  AST_BUSY_HOLD: assert property ($rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  AST_CONV_TIME: assert property (busy_cyc_r < 13'd4400)
    else $error("conversion too long");
  AST_RISE_COUNT: assert property ($fell(busy) |-> rise_cnt_r inside {[5'd9:5'd17]})
    else $error("wrong gated clock rise count");
  AST_CLK_IDLE: assert property (!busy |-> !gated_clk)
    else $error("gated clock runs while idle");
  AST_GCLK_HIGH: assert property ($rose(gated_clk) |-> gated_clk[*4])
    else $error("gated clock high phase short");
  AST_DATA_LEAD: assert property ($fell(busy) |-> $past(data_n, 5) == data_n)
    else $error("result changed within lead time");
  AST_DATA_HOLD: assert property (!busy && !$past(reset) |-> $stable(data_n))
    else $error("result changed while idle");
  AST_REQ_SHORT: assert property ($rose(conv_start) |-> ##[1:12] !conv_start)
    else $error("request pulse too long");
endmodule

// [sar_link_if.sv]
`timescale 1ns/1ns
interface sar_link_if;
  logic                      conv_start;
  logic                      busy;
  logic                      gated_clk;
  logic [sar_pkg::DATA_W-1:0] data_n;

  modport dev (
    input  conv_start,
    output busy,
    output gated_clk,
    output data_n
  );

  modport host (
    output conv_start,
    input  busy,
    input  gated_clk,
    input  data_n
  );
endinterface

// [sar_pkg.sv]
// What this block does
// R1: Request falling edge starts conversion, busy rises.
// R2: Busy stays high until conversion completes.
// R3: Request falling edge clears approximation register first.
// R4: Full scale zeros, midscale 0111, bottom 1110.
// R5: Bipolar offset code, unipolar plain code, both inverted.
// R6: Host inverts MSB for inverted twos code.
// R7: Host holds amplifier on request rising edge.
// R8: Host returns amplifier to track on busy fall.
// R9: Host keeps request pulse short versus conversion.
// R10: Fourteen bits: about 15 us slow, 8 us fast.
// R11: Gated clock runs one cycle per bit plus one (17 at 16 bits), then stays low.
// R12: Result valid 20 ns before busy falls.
// R13: Result pins negative true: logic 1 is low.
// R14: Requests ignored while busy; result held until restart.
package sar_pkg;

  localparam int DATA_W = 16;
  localparam int RES_W  = 5;
  localparam int CNT_W  = 12;

  // Resolution limits for short cycling
  localparam logic [RES_W-1:0] RES_MIN   = 5'h08;
  localparam logic [RES_W-1:0] RES_MAX   = 5'h10;
  localparam logic [RES_W-1:0] RES_SHORT = 5'h0E;

  // Clock rate and timing figures
  localparam int CLK_MHZ        = 250;
  localparam int CONV14_SLOW_NS = 15000;
  localparam int CONV14_FAST_NS = 8000;
  localparam int SHORT_BITS     = 14;
  localparam int DATA_LEAD_NS   = 20;
  localparam int REQ_PULSE_NS   = 40;

  // One gated clock period per bit plus the initial reset edge
  localparam int BIT_CYC_SLOW = CONV14_SLOW_NS * CLK_MHZ / 1000 / (SHORT_BITS + 1);
  localparam int BIT_CYC_FAST = CONV14_FAST_NS * CLK_MHZ / 1000 / (SHORT_BITS + 1);
  localparam logic [CNT_W-1:0] HALF_SLOW = CNT_W'(BIT_CYC_SLOW / 2);
  localparam logic [CNT_W-1:0] HALF_FAST = CNT_W'(BIT_CYC_FAST / 2);
  localparam logic [CNT_W-1:0] DATA_LEAD_CYC = CNT_W'((DATA_LEAD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] REQ_PULSE_CYC = CNT_W'((REQ_PULSE_NS * CLK_MHZ + 999) / 1000);

  // Output code patterns at the nominal transitions
  localparam logic [DATA_W-1:0] CODE_POS_FULL = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_MID      = 16'h7FFF;
  localparam logic [DATA_W-1:0] CODE_NEG_FULL = 16'hFFFE;
  localparam logic [DATA_W-1:0] MSB_MASK      = 16'h8000;
  localparam logic [DATA_W-1:0] ZERO_WORD     = 16'h0000;

  typedef enum logic [1:0] {
    inverted_plain_code  = 2'b00,
    inverted_offset_code = 2'b01,
    inverted_twos_code   = 2'b10
  } code_kind_t;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_CONV = 2'b01,
    DEV_LEAD = 2'b10
  } dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE  = 2'b00,
    HOST_PULSE = 2'b01,
    HOST_WAIT  = 2'b10
  } host_state_t;

endpackage
